/* File: rtl/uiop_pkg.sv */
// Purpose: constants for the io and power control register block
// Assumes: classic wishbone slave, 8-bit register in the low data bits
// Notes: printed offsets are register indexes; byte address is index times four
package uiop_pkg;
  localparam logic [7:0] IDX_CTRL = 8'h39;
  localparam logic [7:0] IDX_SET = 8'h3a;
  localparam logic [7:0] IDX_CLR = 8'h3b;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SET = {IDX_SET, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CLR = {IDX_CLR, 2'b00};
  localparam int BIT_SWAP = 1;
  localparam int UART_LVL_LO = 2;
  localparam int BIT_PU_PLUS = 4;
  localparam int BIT_PU_MINUS = 5;
  localparam int USB_LVL_LO = 6;
  localparam logic [7:0] WR_MASK = 8'hfe;
  localparam logic [7:0] CTRL_RESET = 8'h04;
  localparam logic [1:0] LVL_3V3 = 2'h0;
  typedef enum logic [1:0] {UIOP_USB, UIOP_UART, UIOP_AUDIO} uiop_mode_e;
endpackage

/* File: rtl/uiop_ctrl.sv */
// Purpose: io and power control register with write, set and clear aliases
// Assumes: mode inputs come from the transceiver mode logic, synchronous to I_CLK
// Notes: register answers in one cycle; bit 0 is reserved and reads zero
// What this block does
// - Three read addresses: write, set, clear.
// - Bit 1 swaps plus and minus lines.
// - Swap reroutes uart, never speaker outputs.
// - Bits 3:2 uart regulator level, reset 01.
// - Uart level applied only after transmit enable.
// - Audio mode holds regulator at 3.3V.
// - Bits 4,5 pull-ups; forced on in uart.
// - Bits 7:6 usb regulator level, reset 00.
`timescale 1ns/1ps
module uiop_ctrl (
  input wire logic I_CLK, // 20 MHz clock
  input wire logic I_RESETN, // synchronous reset, active low
  input wire logic I_WB_CYC, // wishbone cycle
  input wire logic I_WB_STB, // wishbone strobe
  input wire logic I_WB_WE, // wishbone write
  input wire logic [3:0] I_WB_SEL, // byte selects
  input wire logic [9:0] I_WB_ADR, // byte address
  input wire logic [31:0] I_WB_DAT, // write data
  input wire logic I_MODE_UART, // transceiver in uart mode
  input wire logic I_MODE_AUDIO, // transceiver in audio mode
  input wire logic I_UART_TRANSMIT_ENABLE, // uart transmit enable
  input wire logic I_UART_TX, // uart transmit data in
  input wire logic I_LEFT_SPEAKER, // left audio in
  input wire logic I_RIGHT_SPEAKER, // right audio in
  output logic [31:0] O_WB_DAT, // read data
  output logic O_WB_ACK, // wishbone ack
  output logic O_WB_ERR, // unmapped access
  output logic O_LINE_SWAP, // plus/minus pins exchanged
  output logic O_PLUS_LINE_CHARGE_PULLUP_ENABLE, // pull-up on plus line
  output logic O_MINUS_LINE_CHARGE_PULLUP_ENABLE, // pull-up on minus line
  output logic [1:0] O_REGULATOR_LEVEL, // supply pin level select
  output logic O_PLUS_UART, // uart tx toward plus pin
  output logic O_LEFT_SPEAKER_OUT, // left speaker, never swapped
  output logic O_RIGHT_SPEAKER_OUT // right speaker, never swapped
);
  logic [7:0] ctrl, next_ctrl;
  logic ack, next_ack, err, next_err;
  logic [31:0] rdat, next_rdat;
  logic uart_armed, next_uart_armed;
  logic swap, next_swap, pu_p, next_pu_p, pu_m, next_pu_m, ptx, next_ptx;
  logic [1:0] lvl, next_lvl;
  logic left_speaker_out, next_left_speaker_out, right_speaker_out, next_right_speaker_out;
  logic req, hit, lane0;
  uiop_pkg::uiop_mode_e mode;

  function automatic logic is_reg(input logic [9:0] a);
    is_reg = (a == uiop_pkg::ADDR_CTRL) || (a == uiop_pkg::ADDR_SET) ||
             (a == uiop_pkg::ADDR_CLR);
  endfunction

  // audio wins when both mode inputs are high
  always_comb begin
    if (I_MODE_AUDIO) mode = uiop_pkg::UIOP_AUDIO;
    else if (I_MODE_UART) mode = uiop_pkg::UIOP_UART;
    else mode = uiop_pkg::UIOP_USB;
  end

  // req drops while ack or err stands, so a held request is taken only once
  assign req = I_WB_CYC && I_WB_STB && !ack && !err;
  assign hit = is_reg(I_WB_ADR);
  assign lane0 = I_WB_SEL[0];

  always_comb begin
    next_ctrl = ctrl;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdat = rdat;
    if (req && hit) begin
      next_ack = 1'b1;
      next_rdat = {24'h000000, ctrl};
      // bit 0 is reserved: the mask keeps it zero on write and set
      if (I_WB_WE && lane0) begin
        case (I_WB_ADR)
          uiop_pkg::ADDR_CTRL: next_ctrl = I_WB_DAT[7:0] & uiop_pkg::WR_MASK;
          uiop_pkg::ADDR_SET: next_ctrl = ctrl | (I_WB_DAT[7:0] & uiop_pkg::WR_MASK);
          uiop_pkg::ADDR_CLR: next_ctrl = ctrl & ~I_WB_DAT[7:0];
          default: next_ctrl = ctrl;
        endcase
      end
    end else if (req) begin
      next_err = 1'b1;
      next_rdat = 32'h00000000;
    end
  end

  // uart level waits for transmit enable; armed state ends when uart mode ends
  always_comb begin
    next_uart_armed = uart_armed;
    if (mode != uiop_pkg::UIOP_UART) next_uart_armed = 1'b0;
    else if (I_UART_TRANSMIT_ENABLE) next_uart_armed = 1'b1;
    next_swap = ctrl[uiop_pkg::BIT_SWAP];
    next_pu_p = ctrl[uiop_pkg::BIT_PU_PLUS];
    next_pu_m = ctrl[uiop_pkg::BIT_PU_MINUS];
    next_lvl = ctrl[uiop_pkg::USB_LVL_LO +: 2];
    next_ptx = 1'b1;
    case (mode)
      uiop_pkg::UIOP_AUDIO: next_lvl = uiop_pkg::LVL_3V3;
      uiop_pkg::UIOP_UART: begin
        next_pu_p = 1'b1;
        next_pu_m = 1'b1;
        if (uart_armed || I_UART_TRANSMIT_ENABLE)
          next_lvl = ctrl[uiop_pkg::UART_LVL_LO +: 2];
        // swapped: tx goes to minus pin, plus pin idles high
        next_ptx = ctrl[uiop_pkg::BIT_SWAP] ? 1'b1 : I_UART_TX;
      end
      default: ;
    endcase
    next_left_speaker_out = I_LEFT_SPEAKER;
    next_right_speaker_out = I_RIGHT_SPEAKER;
  end

  // one register bank; reset is synchronous like every other input
  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      ctrl <= uiop_pkg::CTRL_RESET;
      ack <= 1'b0;
      err <= 1'b0;
      rdat <= 32'h00000000;
      uart_armed <= 1'b0;
      swap <= 1'b0;
      pu_p <= 1'b0;
      pu_m <= 1'b0;
      lvl <= uiop_pkg::LVL_3V3;
      ptx <= 1'b1;
      left_speaker_out <= 1'b0;
      right_speaker_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ack <= next_ack;
      err <= next_err;
      rdat <= next_rdat;
      uart_armed <= next_uart_armed;
      swap <= next_swap;
      pu_p <= next_pu_p;
      pu_m <= next_pu_m;
      lvl <= next_lvl;
      ptx <= next_ptx;
      left_speaker_out <= next_left_speaker_out;
      right_speaker_out <= next_right_speaker_out;
    end
  end

  // outputs come straight from registers, no logic between flop and pin
  assign O_WB_DAT = rdat;
  assign O_WB_ACK = ack;
  assign O_WB_ERR = err;
  assign O_LINE_SWAP = swap;
  assign O_PLUS_LINE_CHARGE_PULLUP_ENABLE = pu_p;
  assign O_MINUS_LINE_CHARGE_PULLUP_ENABLE = pu_m;
  assign O_REGULATOR_LEVEL = lvl;
  assign O_PLUS_UART = ptx;
  assign O_LEFT_SPEAKER_OUT = left_speaker_out;
  assign O_RIGHT_SPEAKER_OUT = right_speaker_out;

  // each check except reserved_zero_a looks one edge after the request or input that it follows
  set_or_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    req && hit && I_WB_WE && lane0 && I_WB_ADR == uiop_pkg::ADDR_SET
    |=> ((ctrl & ($past(I_WB_DAT[7:0]) & uiop_pkg::WR_MASK)) ==
         ($past(I_WB_DAT[7:0]) & uiop_pkg::WR_MASK)))
    else $error("set write lost a bit");
  clr_and_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    req && hit && I_WB_WE && lane0 && I_WB_ADR == uiop_pkg::ADDR_CLR
    |=> ((ctrl & $past(I_WB_DAT[7:0])) == 8'h00))
    else $error("clear write left a bit");
  write_store_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    req && hit && I_WB_WE && lane0 && I_WB_ADR == uiop_pkg::ADDR_CTRL
    |=> ctrl == ($past(I_WB_DAT[7:0]) & uiop_pkg::WR_MASK))
    else $error("plain write not stored");
  reserved_zero_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    (ctrl & ~uiop_pkg::WR_MASK) == 8'h00)
    else $error("reserved bit set");
  read_data_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    req && hit |=> O_WB_ACK && O_WB_DAT[7:0] == $past(ctrl) && O_WB_DAT[31:8] == 24'h000000)
    else $error("read data mismatch");
  err_unmapped_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    req && !hit |=> O_WB_ERR && !O_WB_ACK && O_WB_DAT == 32'h00000000)
    else $error("unmapped access not refused");
  swap_follow_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    ##1 O_LINE_SWAP == $past(ctrl[uiop_pkg::BIT_SWAP]))
    else $error("swap output stale");
  uart_route_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    I_MODE_UART && !I_MODE_AUDIO |=> O_PLUS_UART ==
    ($past(ctrl[uiop_pkg::BIT_SWAP]) ? 1'b1 : $past(I_UART_TX)))
    else $error("uart not routed by swap");
  uart_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !I_MODE_UART || I_MODE_AUDIO |=> O_PLUS_UART)
    else $error("plus pin not idle outside uart");
  audio_level_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    I_MODE_AUDIO |=> O_REGULATOR_LEVEL == uiop_pkg::LVL_3V3)
    else $error("audio mode not at top level");
  uart_pullup_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    I_MODE_UART && !I_MODE_AUDIO |=> O_PLUS_LINE_CHARGE_PULLUP_ENABLE &&
    O_MINUS_LINE_CHARGE_PULLUP_ENABLE)
    else $error("uart pull-ups not forced");
  pullup_follow_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !I_MODE_UART || I_MODE_AUDIO |=> O_PLUS_LINE_CHARGE_PULLUP_ENABLE ==
    $past(ctrl[uiop_pkg::BIT_PU_PLUS]) && O_MINUS_LINE_CHARGE_PULLUP_ENABLE ==
    $past(ctrl[uiop_pkg::BIT_PU_MINUS]))
    else $error("pull-up does not follow its bit");
  uart_wait_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !I_MODE_UART ##1 (I_MODE_UART && !I_MODE_AUDIO && !I_UART_TRANSMIT_ENABLE)
    |=> O_REGULATOR_LEVEL == $past(ctrl[uiop_pkg::USB_LVL_LO +: 2]))
    else $error("uart level applied early");
  uart_level_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    I_MODE_UART && !I_MODE_AUDIO && I_UART_TRANSMIT_ENABLE
    |=> O_REGULATOR_LEVEL == $past(ctrl[uiop_pkg::UART_LVL_LO +: 2]))
    else $error("uart level not applied");
  usb_level_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    !I_MODE_UART && !I_MODE_AUDIO
    |=> O_REGULATOR_LEVEL == $past(ctrl[uiop_pkg::USB_LVL_LO +: 2]))
    else $error("usb level wrong");
  speaker_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $past(I_RESETN) |-> O_LEFT_SPEAKER_OUT == $past(I_LEFT_SPEAKER))
    else $error("speaker altered");
  speaker_right_a: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    $past(I_RESETN) |-> O_RIGHT_SPEAKER_OUT == $past(I_RIGHT_SPEAKER))
    else $error("right speaker altered");
endmodule

/* File: bench/uiop_link.sv */
// Purpose: link controller model issuing register reads, writes, sets and clears
// Assumes: classic wishbone single cycles, one request at a time
// Notes: holds every request until ack or err is sampled high at a rising edge
`timescale 1ns/1ps
module uiop_link (
  input wire logic clk, // bus clock
  input wire logic ack, // slave ack
  input wire logic err, // slave error
  input wire logic [31:0] dat_i, // read data
  output logic cyc, // cycle
  output logic stb, // strobe
  output logic we, // write
  output logic [3:0] sel, // byte selects
  output logic [9:0] adr, // byte address
  output logic [31:0] dat_o // write data
);
  initial begin
    {cyc, stb, we, sel, adr, dat_o} = '0;
  end
  // write, set and clear use separate addresses, reads work at all three
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    dat_o <= d;
    do @(posedge clk); while (!(ack === 1'b1 || err === 1'b1));
    q = dat_i;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
endmodule

/* File: bench/usb_io_power_mgmt_register_test.sv */
// Purpose: self-checking bench for the io and power control register
// Assumes: outputs settle one edge after an input or register change
// Notes: mode inputs are driven directly; the link model does the bus cycles
`timescale 1ns/1ps
module usb_io_power_mgmt_register_test;
  logic clk = 0, rst_n = 0, uart = 0, aud = 0, txen = 0, tx = 0, spl = 1, spr = 0;
  logic cyc, stb, we, ack, err, swap, pup, pum, pu, spkl, spkr;
  logic [3:0] sel;
  logic [9:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [1:0] lvl;
  int n_mismatch = 0, comparisons = 0;
  initial forever #25 clk = ~clk;
  uiop_ctrl dut (.I_CLK(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_SEL(sel), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_MODE_UART(uart), .I_MODE_AUDIO(aud),
    .I_UART_TRANSMIT_ENABLE(txen), .I_UART_TX(tx), .I_LEFT_SPEAKER(spl),
    .I_RIGHT_SPEAKER(spr), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_WB_ERR(err),
    .O_LINE_SWAP(swap), .O_PLUS_LINE_CHARGE_PULLUP_ENABLE(pup),
    .O_MINUS_LINE_CHARGE_PULLUP_ENABLE(pum), .O_REGULATOR_LEVEL(lvl), .O_PLUS_UART(pu),
    .O_LEFT_SPEAKER_OUT(spkl), .O_RIGHT_SPEAKER_OUT(spkr));
  uiop_link u_link (.clk(clk), .ack(ack), .err(err), .dat_i(rdat), .cyc(cyc), .stb(stb),
    .we(we), .sel(sel), .adr(adr), .dat_o(wdat));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // modes change one edge, then three more edges let the registered outputs follow
  task automatic setm(input logic u, input logic a, input logic t);
    @(posedge clk);
    uart <= u;
    aud <= a;
    txen <= t;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    u_link.xfer(1'b0, uiop_pkg::ADDR_CTRL, 0, q);
    chk("reset value", q, 32'h04);
    u_link.xfer(1'b1, uiop_pkg::ADDR_CTRL, 32'hff, q);
    for (int i = 0; i < 3; i++) begin
      u_link.xfer(1'b0, uiop_pkg::ADDR_CTRL + 10'(i * 4), 0, q);
      chk("alias read", q, 32'hfe);
    end
    u_link.xfer(1'b1, uiop_pkg::ADDR_CLR, 32'h0c, q);
    u_link.xfer(1'b0, uiop_pkg::ADDR_SET, 0, q);
    chk("after clear", q, 32'hf2);
    u_link.xfer(1'b1, uiop_pkg::ADDR_SET, 32'h04, q);
    u_link.xfer(1'b0, uiop_pkg::ADDR_CLR, 0, q);
    chk("after set", q, 32'hf6);
    chk("swap", swap, 1);
    setm(1'b1, 1'b0, 1'b0);
    chk("swapped uart plus", pu, 1);
    u_link.xfer(1'b1, uiop_pkg::ADDR_CTRL, 32'h48, q);
    repeat (2) @(posedge clk);
    chk("uart pullups", {pup, pum}, 2'b11);
    chk("level before txen", lvl, 2'b01);
    chk("plain uart plus", pu, 0);
    setm(1'b1, 1'b0, 1'b1);
    chk("level uart", lvl, 2'b10);
    // swap on and plus pull-up bit set before audio: speakers must stay put
    u_link.xfer(1'b1, uiop_pkg::ADDR_SET, 32'h12, q);
    setm(1'b0, 1'b1, 1'b0);
    chk("level audio", lvl, 2'b00);
    chk("speakers", {spkl, spkr}, 2'b10);
    setm(1'b0, 1'b0, 1'b0);
    chk("level usb", lvl, 2'b01);
    chk("pullups follow bits", {pup, pum}, 2'b10);
    setm(1'b1, 1'b0, 1'b1);
    // uart mode is left through the reset pin, as the link is advised to do
    rst_n <= 1'b0;
    uart <= 1'b0;
    txen <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    u_link.xfer(1'b0, uiop_pkg::ADDR_CTRL, 0, q);
    chk("after reset pin", q, 32'h04);
    chk("swap after reset", swap, 0);
    chk("pullups after reset", {pup, pum}, 2'b00);
    chk("level after reset", lvl, 2'b00);
    u_link.xfer(1'b0, 10'h3f0, 0, q);
    chk("unmapped data", q, 0);
    chk("unmapped err", {ack, err}, 2'b01);
    give_verdict();
  end
endmodule
